//--- src/svog_gate.sv
// servo enable and overtravel gating: decides motor excitation, maps the
// forward reference to a rotation sense, blocks motion into open limits and
// sequences the overtravel stop.
// assumes reference, standstill and encoder pins synchronous to hclk (the rest are synchronised), one AHB-Lite master, no other clock.
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module svog_gate
  import svog_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        main_power_ok,
  input  wire logic        servo_on_n_in,
  input  wire logic        fwd_limit_in,
  input  wire logic        rev_limit_in,
  input  wire logic        error_clear_in,
  input  wire logic        fwd_ref_in,
  input  wire logic        rev_ref_in,
  input  wire logic        motor_stopped_in,
  input  wire logic        enc_a_in,
  input  wire logic        enc_b_in,
  output logic             servo_ready,
  output logic             motor_enable,
  output logic             ref_accept,
  output logic             motor_ccw,
  output logic             motor_cw,
  output logic             fwd_permit,
  output logic             rev_permit,
  output logic             dyn_brake,
  output logic             plug_brake,
  output logic             zero_clamp,
  output logic             error_clear_out,
  output logic             enc_a_out,
  output logic             enc_b_out,
  output logic             irq
);

  // synchroniser stages: index 0 power, 1 servo-on, 2 fwd, 3 rev, 4 clear
  logic [SVOG_SYNC_W-1:0] raw_in;
  logic [SVOG_SYNC_W-1:0] meta_r;
  logic [SVOG_SYNC_W-1:0] sync_r;
  logic                   pwr_d_r;
  logic                   pwr_s;
  logic                   son_n_s;
  logic                   fwd_s;
  logic                   rev_s;
  logic                   clr_s;
  logic                   pwr_rise;

  // stored parameters and their power-up copies
  logic [15:0]            basic_r;
  logic [15:0]            dir_r;
  logic [SVOG_STOP_W-1:0] stop_r;
  logic                   son_src_act_r;
  logic                   fwd_dis_act_r;
  logic                   rev_dis_act_r;
  logic                   dir_act_r;
  logic [SVOG_STOP_W-1:0] stop_act_r;
  logic                   ready_r;

  // gating decisions
  logic                   en_req;
  logic                   fwd_ot;
  logic                   rev_ot;
  logic                   fwd_block;
  logic                   rev_block;
  logic                   blocked;
  logic                   plug_code;
  logic                   zc_code;
  logic                   db_on_off;
  svog_state_type         state_r;
  svog_state_type         state_nxt;
  logic                   son_n_d_r;

  // bus and interrupt state
  logic                   wr_pend_r;
  logic [7:0]             wr_addr_r;
  logic                   addr_ok;
  logic [7:0]             ofs;
  logic [31:0]            rd_nxt;
  logic [SVOG_EV_W-1:0]   ev_st_r;
  logic [SVOG_EV_W-1:0]   ev_mk_r;
  logic [SVOG_EV_W-1:0]   ev_set;
  logic [SVOG_EV_W-1:0]   ev_clr;
  logic [5:0]             status_w;

  assign raw_in = {error_clear_in, rev_limit_in, fwd_limit_in, servo_on_n_in, main_power_ok};

  // two flops per input; only the second stage feeds any decision
  for (genvar i = 0; i < SVOG_SYNC_W; i++)
  begin : g_sync
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        // servo-on idles high; resetting its stages low would fake an edge
        meta_r[i] <= (i == 1) ? 1'b1 : 1'b0;
        sync_r[i] <= (i == 1) ? 1'b1 : 1'b0;
      end
      else if (ce)
      begin
        meta_r[i] <= raw_in[i];
        sync_r[i] <= meta_r[i];
      end
    end
  end

  assign pwr_s    = sync_r[0];
  assign son_n_s  = sync_r[1];
  assign fwd_s    = sync_r[2];
  assign rev_s    = sync_r[3];
  assign clr_s    = sync_r[4];
  assign pwr_rise = pwr_s & ~pwr_d_r;

  // power-up latch: later writes wait for the next power cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pwr_d_r       <= 1'b0;
      son_src_act_r <= 1'b0;
      fwd_dis_act_r <= 1'b0;
      rev_dis_act_r <= 1'b0;
      dir_act_r     <= 1'b0;
      stop_act_r    <= SVOG_STOP_RST;
      ready_r       <= 1'b0;
    end
    else if (ce)
    begin
      pwr_d_r <= pwr_s;
      if (pwr_rise)
      begin
        son_src_act_r <= basic_r[SVOG_SON_SRC_BIT];
        fwd_dis_act_r <= basic_r[SVOG_FWD_DIS_BIT];
        rev_dis_act_r <= basic_r[SVOG_REV_DIS_BIT];
        dir_act_r     <= dir_r[SVOG_DIR_BIT];
        stop_act_r    <= stop_r;
      end
      ready_r <= pwr_s & pwr_d_r; // ready one cycle after the latch
    end
  end

  // enable source and limit evaluation; limits work in every control mode
  assign en_req    = ready_r & (son_src_act_r | ~son_n_s);
  assign fwd_ot    = fwd_s & ~fwd_dis_act_r;
  assign rev_ot    = rev_s & ~rev_dis_act_r;
  assign fwd_block = fwd_ref_in & fwd_ot;
  assign rev_block = rev_ref_in & rev_ot;
  assign blocked   = fwd_block | rev_block;
  assign plug_code = (stop_act_r >= SVOG_STOP_PLUG_LO) && (stop_act_r <= SVOG_STOP_MAX);
  assign zc_code   = (stop_act_r >= SVOG_STOP_ZC_LO) && (stop_act_r <= SVOG_STOP_MAX);
  // servo-off stop: even codes brake dynamically, odd codes coast
  assign db_on_off = ~stop_act_r[0];

  // stop sequencer
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SVOG_OFF:
        if (en_req)
          state_nxt = SVOG_RUN;
      SVOG_RUN:
        if (!en_req)
          state_nxt = SVOG_OFF;
        else if (blocked)
          state_nxt = SVOG_BRAKE;
      SVOG_BRAKE:
        if (!en_req)
          state_nxt = SVOG_OFF;
        else if (motor_stopped_in)
          state_nxt = SVOG_HOLD;
      SVOG_HOLD:
        if (!en_req)
          state_nxt = SVOG_OFF;
        else if (!blocked)
          state_nxt = SVOG_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_r <= SVOG_OFF;
    else if (ce)
      state_r <= state_nxt;
  end

  // motor drive outputs follow the next state so they change with it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      motor_enable <= 1'b0;
      ref_accept   <= 1'b0;
      motor_ccw    <= 1'b0;
      motor_cw     <= 1'b0;
      fwd_permit   <= 1'b0;
      rev_permit   <= 1'b0;
      dyn_brake    <= 1'b0;
      plug_brake   <= 1'b0;
      zero_clamp   <= 1'b0;
      servo_ready  <= 1'b0;
    end
    else if (ce)
    begin
      servo_ready  <= ready_r;
      ref_accept   <= state_nxt == SVOG_RUN;
      motor_enable <= (state_nxt == SVOG_RUN)
                      || (state_nxt == SVOG_BRAKE && plug_code)
                      || (state_nxt == SVOG_HOLD && zc_code);
      fwd_permit   <= (state_nxt != SVOG_OFF) && !fwd_ot;
      rev_permit   <= (state_nxt != SVOG_OFF) && !rev_ot;
      // a lone forward reference turns ccw unless the sense is swapped
      motor_ccw    <= (state_nxt == SVOG_RUN)
                      && ((fwd_ref_in && !rev_ref_in && !fwd_ot && !dir_act_r)
                      ||  (rev_ref_in && !fwd_ref_in && !rev_ot &&  dir_act_r));
      motor_cw     <= (state_nxt == SVOG_RUN)
                      && ((fwd_ref_in && !rev_ref_in && !fwd_ot &&  dir_act_r)
                      ||  (rev_ref_in && !fwd_ref_in && !rev_ot && !dir_act_r));
      dyn_brake    <= ((state_nxt == SVOG_BRAKE) && stop_act_r == SVOG_STOP_DB)
                      || ((state_nxt == SVOG_OFF) && db_on_off && !motor_stopped_in);
      plug_brake   <= (state_nxt == SVOG_BRAKE) && plug_code;
      zero_clamp   <= (state_nxt == SVOG_HOLD) && zc_code;
    end
  end

  // error pulses are only dropped on the host's clear; overtravel keeps them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      error_clear_out <= 1'b0;
    else if (ce)
      error_clear_out <= clr_s;
  end

  // encoder division output passes unchanged whatever the direction field
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      enc_a_out <= 1'b0;
      enc_b_out <= 1'b0;
    end
    else if (ce)
    begin
      enc_a_out <= enc_a_in;
      enc_b_out <= enc_b_in;
    end
  end

  // AHB-Lite slave: zero wait states, address captured for the data phase
  assign ofs     = haddr[7:0];
  assign addr_ok = (haddr[31:8] == 24'h000000) && (ofs[1:0] == 2'b00);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else if (ce && hready)
    begin
      wr_pend_r <= hsel && htrans[1] && hwrite && addr_ok;
      wr_addr_r <= ofs;
    end
  end

  assign status_w = {state_r == SVOG_HOLD && zc_code, state_r == SVOG_HOLD,
                     rev_ot, fwd_ot, state_r != SVOG_OFF, ready_r};

  // read data is registered at the address phase; unmapped reads give zero
  always_comb
  begin
    rd_nxt = 32'h00000000;
    if (addr_ok)
    begin
      unique case (ofs)
        SVOG_BASIC_OFS:  rd_nxt = {16'h0000, basic_r};
        SVOG_DIR_OFS:    rd_nxt = {16'h0000, dir_r};
        SVOG_STOP_OFS:   rd_nxt = {28'h0000000, stop_r};
        SVOG_STATUS_OFS: rd_nxt = {26'h0000000, status_w};
        SVOG_IRQ_ST_OFS: rd_nxt = {28'h0000000, ev_st_r};
        SVOG_IRQ_MK_OFS: rd_nxt = {28'h0000000, ev_mk_r};
        default:         rd_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (ce && hready && hsel && htrans[1] && !hwrite)
      hrdata <= rd_nxt;
  end

  // parameter stores: written any time, acted on at the next power-up; the event mask acts at once
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      basic_r <= SVOG_BASIC_RST;
      dir_r   <= SVOG_DIR_RST;
      stop_r  <= SVOG_STOP_RST;
      ev_mk_r <= SVOG_MASK_RST;
    end
    else if (ce && wr_pend_r)
    begin
      if (wr_addr_r == SVOG_BASIC_OFS)
        basic_r <= hwdata[15:0];
      if (wr_addr_r == SVOG_DIR_OFS)
        dir_r <= hwdata[15:0];
      if (wr_addr_r == SVOG_STOP_OFS)
        stop_r <= hwdata[SVOG_STOP_W-1:0];
      if (wr_addr_r == SVOG_IRQ_MK_OFS)
        ev_mk_r <= hwdata[SVOG_EV_W-1:0];
    end
  end

  // events: overtravel entries, stop reached, servo-on edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      son_n_d_r <= 1'b1;
    else if (ce)
      son_n_d_r <= son_n_s;
  end

  always_comb
  begin
    ev_set                  = '0;
    ev_set[SVOG_EV_FWD_OT]  = fwd_block && state_r == SVOG_RUN;
    ev_set[SVOG_EV_REV_OT]  = rev_block && state_r == SVOG_RUN;
    ev_set[SVOG_EV_STOPPED] = state_r == SVOG_BRAKE && state_nxt == SVOG_HOLD;
    ev_set[SVOG_EV_SON_CHG] = son_n_s ^ son_n_d_r;
    ev_clr = (wr_pend_r && wr_addr_r == SVOG_IRQ_ST_OFS) ? hwdata[SVOG_EV_W-1:0] : '0;
  end

  // a set in the cycle of its clear wins, so no event is lost
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ev_st_r <= '0;
      irq     <= 1'b0;
    end
    else if (ce)
    begin
      ev_st_r <= (ev_st_r & ~ev_clr) | ev_set;
      irq     <= |(((ev_st_r & ~ev_clr) | ev_set) & ev_mk_r);
    end
  end

  // checks on the gating outputs
  a_son_energise: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && en_req && state_r == SVOG_RUN && !blocked) |=> (motor_enable && ref_accept))
    else $error("motor not energised while servo-on active");

  a_son_removed: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !en_req) |=> (!ref_accept && !motor_ccw && !motor_cw))
    else $error("references accepted while servo-on inactive");

  a_ext_source: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !son_src_act_r && son_n_s && state_r == SVOG_OFF) |=> state_r == SVOG_OFF)
    else $error("external source enabled without servo-on");

  a_auto_source: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && son_src_act_r && ready_r && state_r == SVOG_OFF) |=> state_r == SVOG_RUN)
    else $error("automatic source did not enable after ready");

  a_cfg_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
    (!(ce && pwr_rise)) |=> $stable({son_src_act_r, fwd_dis_act_r, rev_dis_act_r,
                                     dir_act_r, stop_act_r}))
    else $error("active configuration changed outside power-up");

  a_dir_sense: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && state_nxt == SVOG_RUN && fwd_ref_in && !rev_ref_in && !fwd_ot)
    |=> (dir_act_r ? (motor_cw && !motor_ccw) : (motor_ccw && !motor_cw)))
    else $error("forward reference drove the wrong sense");

  a_enc_pass: assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> (enc_a_out == $past(enc_a_in) && enc_b_out == $past(enc_b_in)))
    else $error("encoder output altered");

  a_fwd_block: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && fwd_s && !fwd_dis_act_r) |=> !fwd_permit)
    else $error("forward permitted with forward limit open");

  a_rev_block: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && rev_s && !rev_dis_act_r) |=> !rev_permit)
    else $error("reverse permitted with reverse limit open");

  a_fwd_disabled: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && fwd_dis_act_r && state_nxt == SVOG_RUN) |=> fwd_permit)
    else $error("disabled forward limit still blocks");

  a_ot_zero_clamp: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && state_r == SVOG_BRAKE && en_req && motor_stopped_in)
    |=> (zero_clamp == zc_code && !plug_brake))
    else $error("wrong mode after overtravel stop");

  a_err_retained: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !clr_s) |=> !error_clear_out)
    else $error("error pulses cleared without clear input");

endmodule

`default_nettype wire

//--- src/svog_pkg.sv
// package for the servo enable and overtravel gating block:
// register offsets, field positions, reset values, stop methods and states.
// assumes a single 40 MHz clock domain and an AHB-Lite register port.
package svog_pkg;

  // byte addresses of the register words
  localparam logic [7:0] SVOG_BASIC_OFS  = 8'h00; // basic_function_switches
  localparam logic [7:0] SVOG_DIR_OFS    = 8'h04; // rotation_direction_switch
  localparam logic [7:0] SVOG_STOP_OFS   = 8'h08; // stop_method_select
  localparam logic [7:0] SVOG_STATUS_OFS = 8'h0c; // live state, read only
  localparam logic [7:0] SVOG_IRQ_ST_OFS = 8'h10; // sticky events, write one to clear
  localparam logic [7:0] SVOG_IRQ_MK_OFS = 8'h14; // event mask, one enables

  // field positions
  localparam int SVOG_SON_SRC_BIT = 0;  // 0 external servo-on, 1 automatic
  localparam int SVOG_FWD_DIS_BIT = 1;  // 1 ignores the forward limit
  localparam int SVOG_REV_DIS_BIT = 2;  // 1 ignores the reverse limit
  localparam int SVOG_DIR_BIT     = 0;  // 0 ccw forward, 1 cw forward
  localparam int SVOG_STOP_W      = 4;  // stop method nibble width

  // status register bit positions
  localparam int SVOG_ST_READY  = 0;
  localparam int SVOG_ST_ENABLE = 1;
  localparam int SVOG_ST_FWD_OT = 2;
  localparam int SVOG_ST_REV_OT = 3;
  localparam int SVOG_ST_HOLD   = 4;
  localparam int SVOG_ST_CLAMP  = 5;

  // event bit positions, shared by status and mask
  localparam int SVOG_EV_FWD_OT  = 0;
  localparam int SVOG_EV_REV_OT  = 1;
  localparam int SVOG_EV_STOPPED = 2;
  localparam int SVOG_EV_SON_CHG = 3;
  localparam int SVOG_EV_W       = 4;

  // reset values
  localparam logic [15:0]          SVOG_BASIC_RST = 16'h0000;
  localparam logic [15:0]          SVOG_DIR_RST   = 16'h0000;
  localparam logic [SVOG_STOP_W-1:0] SVOG_STOP_RST = 4'h0;
  localparam logic [SVOG_EV_W-1:0] SVOG_MASK_RST  = 4'h0;

  // stop method codes
  localparam logic [SVOG_STOP_W-1:0] SVOG_STOP_DB      = 4'h0; // dynamic brake, then coast
  localparam logic [SVOG_STOP_W-1:0] SVOG_STOP_COAST   = 4'h1; // coast to a stop
  localparam logic [SVOG_STOP_W-1:0] SVOG_STOP_PLUG_LO = 4'h2; // first plug-brake code
  localparam logic [SVOG_STOP_W-1:0] SVOG_STOP_ZC_LO   = 4'h4; // first zero-clamp code
  localparam logic [SVOG_STOP_W-1:0] SVOG_STOP_MAX     = 4'h5; // last legal code

  // synchronised inputs
  localparam int SVOG_SYNC_W = 5;

  // gray coded along off, run, brake, hold
  typedef enum logic [1:0]
  {
    SVOG_OFF   = 2'b00,
    SVOG_RUN   = 2'b01,
    SVOG_BRAKE = 2'b11,
    SVOG_HOLD  = 2'b10
  } svog_state_type;

endpackage

//--- tb/svog_host_model.sv
// model of the host controller and the machine limit switches.
// assumes commands from the bench on hclk; standstill after stop_delay idle cycles.
`timescale 1ns/1ps
`default_nettype none
module svog_host_model
  import svog_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       son,
  input  wire logic       fref,
  input  wire logic       rref,
  input  wire logic       flim,
  input  wire logic       rlim,
  input  wire logic       clr,
  input  wire logic [7:0] stop_delay,
  input  wire logic       motor_ccw,
  input  wire logic       motor_cw,
  output logic            servo_on_n_in,
  output logic            fwd_ref_in,
  output logic            rev_ref_in,
  output logic            fwd_limit_in,
  output logic            rev_limit_in,
  output logic            error_clear_in,
  output logic            motor_stopped_in
);
  logic [7:0] idle_r;

  // pins change just after an edge, as real wiring seen through a register
  always_ff @(posedge hclk)
  begin
    servo_on_n_in  <= ~son;
    fwd_ref_in     <= fref;
    rev_ref_in     <= rref;
    fwd_limit_in   <= flim; // switch open reads high
    rev_limit_in   <= rlim;
    error_clear_in <= clr;
  end

  // the shaft coasts for a while; a large delay models a slow stop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      idle_r <= 8'hff;
    else if (motor_ccw | motor_cw)
      idle_r <= 8'h00;
    else if (idle_r != 8'hff)
      idle_r <= idle_r + 8'h01;
  end

  assign motor_stopped_in = (idle_r >= stop_delay);
endmodule
`default_nettype wire

//--- tb/test_svog_gate.sv
// self-checking bench for the servo gating block over its register bus and pins.
// assumes zero-wait slave but waits on hreadyout; ce held high.
`timescale 1ns/1ps
`default_nettype none
module test_svog_gate;
  import svog_pkg::*;
  logic        hclk, hreadyout, hresp, servo_ready, motor_enable, ref_accept;
  logic        motor_ccw, motor_cw, fwd_permit, rev_permit, dyn_brake, plug_brake;
  logic        zero_clamp, error_clear_out, enc_a_out, enc_b_out, irq;
  logic [31:0] hrdata, exp_q[$];
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, main_power_ok = 1'b0;
  logic        son = 1'b0, fref = 1'b0, rref = 1'b0, flim = 1'b0, rlim = 1'b0;
  logic        clr = 1'b0, enc_a_in = 1'b0, enc_b_in = 1'b0, rd_pend = 1'b0;
  logic [7:0]  stop_delay = 8'h14;
  wire logic   servo_on_n_in, fwd_ref_in, rev_ref_in, fwd_limit_in;
  wire logic   rev_limit_in, error_clear_in, motor_stopped_in;
  wire logic [8:0] pins = {motor_enable, ref_accept, motor_ccw, motor_cw,
                           fwd_permit, rev_permit, dyn_brake, plug_brake, zero_clamp};
  int          errors = 0, n_compared = 0;

  svog_gate svog_gate_inst (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .main_power_ok, .servo_on_n_in, .fwd_limit_in, .rev_limit_in, .error_clear_in,
    .fwd_ref_in, .rev_ref_in, .motor_stopped_in, .enc_a_in, .enc_b_in, .servo_ready,
    .motor_enable, .ref_accept, .motor_ccw, .motor_cw, .fwd_permit, .rev_permit,
    .dyn_brake, .plug_brake, .zero_clamp, .error_clear_out, .enc_a_out, .enc_b_out, .irq);

  svog_host_model svog_host_model_inst (.hclk, .hresetn, .son, .fref, .rref, .flim,
    .rlim, .clr, .stop_delay, .motor_ccw, .motor_cw, .servo_on_n_in, .fwd_ref_in,
    .rev_ref_in, .fwd_limit_in, .rev_limit_in, .error_clear_in, .motor_stopped_in);

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    begin
      n_compared++;
      if (s !== e)
      begin
        errors++;
        $display("mismatch %s expected %h seen %h", nm, e, s);
      end
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // one single word transfer; address then data phase, each held until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    begin
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
    end
  endtask

  // parameters only count after a power cycle, so every new setup goes through here
  task automatic power(input logic [3:0] b, input logic d, input logic [3:0] s);
    begin
      bus(1'b1, SVOG_BASIC_OFS, {28'h0, b});
      bus(1'b1, SVOG_DIR_OFS, {31'h0, d});
      bus(1'b1, SVOG_STOP_OFS, {28'h0, s});
      main_power_ok <= 1'b0;
      cyc(8);
      main_power_ok <= 1'b1;
      cyc(12);
    end
  endtask

  task automatic enc_chk;
    logic [1:0] e;
    begin
      repeat (8)
      begin
        e = 2'($urandom());
        enc_a_in <= e[1];
        enc_b_in <= e[0];
        cyc(2);
        chk("encoder", e, {enc_a_out, enc_b_out});
      end
    end
  endtask

  // read data is taken at the edge closing the data phase
  always @(posedge hclk)
  begin
    if (rd_pend && hreadyout === 1'b1)
      chk("read", exp_q.pop_front(), hrdata);
    if (hreadyout === 1'b1)
      rd_pend <= hsel && htrans[1] && !hwrite;
  end

  initial
  begin
    #1000000;
    errors++;
    test_done();
  end

  initial
  begin
    logic [31:0] d;
    logic        s;
    d = $urandom(48);
    cyc(3);
    hresetn <= 1'b1;
    cyc(2);
    for (int a = 0; a <= 32; a += 4)
      rd(a[7:0], 32'h0);
    chk("okay", 32'h0, hresp);
    bus(1'b1, SVOG_STATUS_OFS, 32'hff);
    rd(SVOG_STATUS_OFS, 32'h0);
    d = $urandom();
    bus(1'b1, SVOG_IRQ_MK_OFS, d);
    rd(SVOG_IRQ_MK_OFS, {28'h0, d[3:0]});
    $display("test registers done");
    // odd codes use the reverse side; code 5 is the vertical axis choice
    for (int c = 0; c < 6; c++)
    begin
      s = c[0];
      power(4'h0, 1'b0, c[3:0]);
      chk("off pins", 32'h0, pins & 9'h1e7);
      chk("servo ready", 32'h1, servo_ready);
      son <= 1'b1;
      cyc(2);
      fref <= ~s;
      rref <= s;
      cyc(8);
      chk("run pins", s ? 32'h1b8 : 32'h1d8, pins);
      rd(SVOG_STATUS_OFS, 32'h3);
      if (c == 0)
        enc_chk();
      bus(1'b1, SVOG_IRQ_ST_OFS, 32'hf);
      bus(1'b1, SVOG_IRQ_MK_OFS, s ? 32'h2 : 32'h1);
      flim <= ~s;
      rlim <= s;
      cyc(7);
      chk("brake pins", {c >= 2, 3'b000, s, ~s, c == 0, c >= 2, 1'b0}, pins);
      chk("irq", 32'h1, irq);
      cyc(40);
      chk("hold pins", {c >= 4, 3'b000, s, ~s, 2'b00, c >= 4}, pins);
      rd(SVOG_STATUS_OFS, {c >= 4, 1'b1, s, ~s, 2'b11});
      rd(SVOG_IRQ_ST_OFS, s ? 32'h6 : 32'h5);
      bus(1'b1, SVOG_IRQ_ST_OFS, s ? 32'h2 : 32'h1);
      cyc(1);
      chk("irq clear", 32'h0, irq);
      {fref, rref, flim, rlim, son} <= 5'h0;
      cyc(8);
      chk("stop pins", 32'h0, pins & 9'h180);
    end
    $display("test stop methods done");
    clr <= 1'b1;
    cyc(2);
    chk("clear early", 32'h0, error_clear_out);
    cyc(5);
    chk("clear out", 32'h1, error_clear_out);
    clr <= 1'b0;
    $display("test error clear done");
    bus(1'b1, SVOG_BASIC_OFS, 32'h7);
    cyc(8);
    chk("no latch", 32'h0, motor_enable);
    rd(SVOG_BASIC_OFS, 32'h7);
    power(4'h7, 1'b1, 4'h5);
    chk("auto pins", 32'h198, pins);
    fref <= 1'b1;
    flim <= 1'b1;
    cyc(8);
    chk("cw fwd", 32'h1b8, pins);
    {fref, flim, rref, rlim} <= 4'h3;
    cyc(8);
    chk("ccw rev", 32'h1d8, pins);
    enc_chk();
    $display("test power-up latch done");
    cyc(2);
    test_done();
  end
endmodule
`default_nettype wire
